// [logic/pid_regs_pkg.sv]
// Package with register map, field layout and factory defaults for the PID parameter bank
`default_nettype none

package pid_regs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  LOOP1_BASE     = 8'h60;  // First index of loop 1 range
  localparam logic [7:0]  LOOP2_BASE     = 8'h80;  // First index of loop 2 range
  localparam logic [7:0]  LOOP_SPAN      = 8'h12;  // Registers per loop
  localparam logic [4:0]  SET_STRIDE     = 5'h05;  // Registers per parameter set
  localparam logic [4:0]  SET1_BASE      = 5'h05;
  localparam logic [4:0]  SET2_BASE      = 5'h0a;
  localparam logic [4:0]  MISC_BASE      = 5'h0f;

  // ----------------------------------------------------------------
  // Field positions inside one parameter set, and loop-wide fields
  // ----------------------------------------------------------------
  localparam logic [4:0]  OFF_GAIN       = 5'h00;
  localparam logic [4:0]  OFF_TI_HIGH    = 5'h01;
  localparam logic [4:0]  OFF_TI_LOW     = 5'h02;
  localparam logic [4:0]  OFF_TD_HIGH    = 5'h03;
  localparam logic [4:0]  OFF_TD_LOW     = 5'h04;
  localparam logic [4:0]  OFF_BIAS       = 5'h0f;
  localparam logic [4:0]  OFF_LIMIT1     = 5'h10;
  localparam logic [4:0]  OFF_LIMIT2     = 5'h11;
  localparam logic [1:0]  SET_MISC       = 2'h3;   // Select code for loop-wide fields

  // ----------------------------------------------------------------
  // Value ranges and factory defaults
  // ----------------------------------------------------------------
  localparam logic [15:0] GAIN_MIN       = 16'h0001;  // Gain 0.01 times one hundred
  localparam logic [15:0] GAIN_MAX       = 16'h2710;  // Gain 100.00 times one hundred
  localparam logic [15:0] GAIN_DEFAULT   = 16'h0064;  // Gain 1.00
  localparam logic [31:0] TIME_DEFAULT   = 32'h0000_0000;
  localparam logic [15:0] WORD_DEFAULT   = 16'h0000;
  localparam logic [15:0] READ_NONSENSE  = 16'h0000;  // Read value on monitoring variant

  // Power-up sequencer
  typedef enum logic [1:0] {PWR_SAMPLE, PWR_RESTORE, PWR_RUN} pwr_state_t;

endpackage

`default_nettype wire

// [logic/pid_loop_bank.sv]
// One loop's PID parameter storage: three sets, staged time words, loop-wide fields
`timescale 1ns/1ps
`default_nettype none

module pid_loop_bank (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        wr_en,
  input  wire logic        restore,
  input  wire logic        mirror,
  input  wire logic [4:0]  offset,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] rd_data
);

  logic [15:0] gain     [3];
  logic [31:0] ti       [3];
  logic [31:0] td       [3];
  logic [15:0] ti_stage [3];
  logic [15:0] td_stage [3];
  logic [15:0] bias;
  logic [15:0] limit1;
  logic [15:0] limit2;
  logic [15:0] next_gain     [3];
  logic [31:0] next_ti       [3];
  logic [31:0] next_td       [3];
  logic [15:0] next_ti_stage [3];
  logic [15:0] next_td_stage [3];
  logic [15:0] next_bias;
  logic [15:0] next_limit1;
  logic [15:0] next_limit2;
  logic [1:0]  sel_set;
  logic [4:0]  sel_field;
  logic [1:0]  rd_set;
  logic [15:0] gain_in;

  // ----------------------------------------------------------------
  // Offset split into set and field
  // ----------------------------------------------------------------
  always_comb begin
    if (offset < pid_regs_pkg::SET1_BASE) begin
      sel_set   = 2'h0;
      sel_field = offset;
    end else if (offset < pid_regs_pkg::SET2_BASE) begin
      sel_set   = 2'h1;
      sel_field = offset - pid_regs_pkg::SET_STRIDE;
    end else if (offset < pid_regs_pkg::MISC_BASE) begin
      sel_set   = 2'h2;
      sel_field = offset - pid_regs_pkg::SET2_BASE;
    end else begin
      sel_set   = pid_regs_pkg::SET_MISC;
      sel_field = offset;
    end
    // Gain is clamped so the controller never sees a gain outside its range
    if (wr_data < pid_regs_pkg::GAIN_MIN) gain_in = pid_regs_pkg::GAIN_MIN; // R9
    else if (wr_data > pid_regs_pkg::GAIN_MAX) gain_in = pid_regs_pkg::GAIN_MAX; // R9
    else gain_in = wr_data;
  end

  // ----------------------------------------------------------------
  // Next state of the parameter table
  // ----------------------------------------------------------------
  always_comb begin
    next_gain     = gain;
    next_ti       = ti;
    next_td       = td;
    next_ti_stage = ti_stage;
    next_td_stage = td_stage;
    next_bias     = bias;
    next_limit1   = limit1;
    next_limit2   = limit2;
    if (restore) begin
      for (int s = 0; s < 3; s++) begin
        next_gain[s]     = pid_regs_pkg::GAIN_DEFAULT;
        next_ti[s]       = pid_regs_pkg::TIME_DEFAULT;
        next_td[s]       = pid_regs_pkg::TIME_DEFAULT;
        next_ti_stage[s] = pid_regs_pkg::WORD_DEFAULT;
        next_td_stage[s] = pid_regs_pkg::WORD_DEFAULT;
      end
      next_bias   = pid_regs_pkg::WORD_DEFAULT;
      next_limit1 = pid_regs_pkg::WORD_DEFAULT;
      next_limit2 = pid_regs_pkg::WORD_DEFAULT;
    end else if (wr_en && sel_set == pid_regs_pkg::SET_MISC) begin
      case (offset)
        pid_regs_pkg::OFF_BIAS:   next_bias   = wr_data;
        pid_regs_pkg::OFF_LIMIT1: next_limit1 = wr_data;
        pid_regs_pkg::OFF_LIMIT2: next_limit2 = wr_data;
        default: ;
      endcase
    end else if (wr_en) begin
      // With scheduling off one write lands in all three sets
      for (int s = 0; s < 3; s++) begin
        if (mirror || 2'(s) == sel_set) begin // R4
          case (sel_field)
            pid_regs_pkg::OFF_GAIN:    next_gain[s]     = gain_in;
            pid_regs_pkg::OFF_TI_HIGH: next_ti_stage[s] = wr_data; // R1
            pid_regs_pkg::OFF_TI_LOW:  next_ti[s] = {ti_stage[sel_set], wr_data}; // R10 R3
            pid_regs_pkg::OFF_TD_HIGH: next_td_stage[s] = wr_data; // R1
            pid_regs_pkg::OFF_TD_LOW:  next_td[s] = {td_stage[sel_set], wr_data}; // R10 R3
            default: ;
          endcase
        end
      end
    end
  end

  // Reads come from set one while mirrored, so stale sets never show
  always_comb begin
    rd_set = (mirror && sel_set != pid_regs_pkg::SET_MISC) ? 2'h0 : sel_set; // R5
    rd_data = pid_regs_pkg::WORD_DEFAULT;
    if (rd_set == pid_regs_pkg::SET_MISC) begin
      case (offset)
        pid_regs_pkg::OFF_BIAS:   rd_data = bias;
        pid_regs_pkg::OFF_LIMIT1: rd_data = limit1;
        pid_regs_pkg::OFF_LIMIT2: rd_data = limit2;
        default:                  rd_data = pid_regs_pkg::WORD_DEFAULT;
      endcase
    end else begin
      case (sel_field)
        pid_regs_pkg::OFF_GAIN:    rd_data = gain[rd_set];
        pid_regs_pkg::OFF_TI_HIGH: rd_data = ti_stage[rd_set];
        pid_regs_pkg::OFF_TI_LOW:  rd_data = ti[rd_set][15:0]; // R3
        pid_regs_pkg::OFF_TD_HIGH: rd_data = td_stage[rd_set];
        pid_regs_pkg::OFF_TD_LOW:  rd_data = td[rd_set][15:0]; // R3
        default:                   rd_data = pid_regs_pkg::WORD_DEFAULT;
      endcase
    end
  end

  // Table registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int s = 0; s < 3; s++) begin
        gain[s]     <= pid_regs_pkg::GAIN_DEFAULT;
        ti[s]       <= pid_regs_pkg::TIME_DEFAULT;
        td[s]       <= pid_regs_pkg::TIME_DEFAULT;
        ti_stage[s] <= pid_regs_pkg::WORD_DEFAULT;
        td_stage[s] <= pid_regs_pkg::WORD_DEFAULT;
      end
      bias   <= pid_regs_pkg::WORD_DEFAULT;
      limit1 <= pid_regs_pkg::WORD_DEFAULT;
      limit2 <= pid_regs_pkg::WORD_DEFAULT;
    end else begin
      gain     <= next_gain;
      ti       <= next_ti;
      td       <= next_td;
      ti_stage <= next_ti_stage;
      td_stage <= next_td_stage;
      bias     <= next_bias;
      limit1   <= next_limit1;
      limit2   <= next_limit2;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_high_held: assert property (@(posedge clock) disable iff (!arst_n) // R1
    (wr_en && !restore && offset == pid_regs_pkg::OFF_TI_HIGH) |=> ti[0] == $past(ti[0]))
    else $error("High word write changed the active integral time");
  chk_pair_combine: assert property (@(posedge clock) disable iff (!arst_n) // R10
    (wr_en && !restore && offset == pid_regs_pkg::OFF_TD_LOW)
    |=> td[0] == {$past(td_stage[0]), $past(wr_data)})
    else $error("Committed derivative time is not staged high plus low word");
  chk_mirror_copy: assert property (@(posedge clock) disable iff (!arst_n) // R4
    (wr_en && !restore && mirror && offset == pid_regs_pkg::SET1_BASE)
    |=> gain[0] == gain[1] && gain[2] == gain[1])
    else $error("Mirrored gain write did not reach all sets");
  chk_gain_range: assert property (@(posedge clock) disable iff (!arst_n) // R9
    gain[2] >= pid_regs_pkg::GAIN_MIN && gain[2] <= pid_regs_pkg::GAIN_MAX)
    else $error("Stored gain outside permitted range");
  chk_read_mirror: assert property (@(posedge clock) disable iff (!arst_n) // R5
    (mirror && offset == pid_regs_pkg::SET2_BASE) |-> rd_data == gain[0])
    else $error("Mirrored read of set three differs from set one");
  chk_low_read: assert property (@(posedge clock) disable iff (!arst_n) // R3
    (offset == pid_regs_pkg::OFF_TI_LOW && !mirror) |-> rd_data == ti[0][15:0])
    else $error("Low register does not read low half of committed time");

endmodule // pid_loop_bank

`default_nettype wire

// [logic/pid_parameter_register_access.sv]
// Top of the PID parameter register bank: index decode, power-up handling, read path
`timescale 1ns/1ps
`default_nettype none

// Function
// [R1] Time value commits only on low-word write
// [R2] Master writes high word first, low last
// [R3] Time is 32-bit milliseconds, high then low
// [R4] Scheduling off: writes copied to all sets
// [R5] Scheduling off: all sets read the same
// [R6] Monitoring variant: PID reads meaningless, writes ignored
// [R7] Cancel plus down at power-up restores defaults
// [R8] Each register holds one unsigned 16-bit word
// [R9] Gain exchanged times hundred, 1 to 10000
// [R10] Low word joins latest high word
module pid_parameter_register_access (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_index,
  input  wire logic [15:0] reg_wr_data,
  input  wire logic        gain_sched_loop1,
  input  wire logic        gain_sched_loop2,
  input  wire logic        monitor_only_strap,
  input  wire logic        cancel_key,
  input  wire logic        down_key,
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  output logic             rd_hit,
  output logic             link_ready,
  output logic             monitor_only,
  output logic             defaults_restored
);

  pid_regs_pkg::pwr_state_t state;
  pid_regs_pkg::pwr_state_t next_state;
  logic        next_monitor_only;
  logic        next_defaults_restored;
  logic        next_link_ready;
  logic [15:0] next_rd_data;
  logic        next_rd_valid;
  logic        next_rd_hit;
  logic        hit1;
  logic        hit2;
  logic [7:0]  rel1;
  logic [7:0]  rel2;
  logic        bank_wr1;
  logic        bank_wr2;
  logic        restore;
  logic [15:0] bank_rd1;
  logic [15:0] bank_rd2;

  // ----------------------------------------------------------------
  // Power-up sequencer
  // ----------------------------------------------------------------
  // Keys and variant strap are sampled once, on the first edge after release,
  // so a key pressed later in operation never wipes the table
  always_comb begin
    next_state             = state;
    next_monitor_only      = monitor_only;
    next_defaults_restored = defaults_restored;
    next_link_ready        = link_ready;
    case (state)
      pid_regs_pkg::PWR_SAMPLE: begin
        next_monitor_only = monitor_only_strap; // R6
        if (cancel_key && down_key) begin
          next_state = pid_regs_pkg::PWR_RESTORE; // R7
        end else begin
          next_state      = pid_regs_pkg::PWR_RUN;
          next_link_ready = 1'b1;
        end
      end
      pid_regs_pkg::PWR_RESTORE: begin
        next_state             = pid_regs_pkg::PWR_RUN;
        next_defaults_restored = 1'b1; // R7
        next_link_ready        = 1'b1;
      end
      pid_regs_pkg::PWR_RUN: next_state = pid_regs_pkg::PWR_RUN;
      default: next_state = pid_regs_pkg::PWR_SAMPLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state             <= pid_regs_pkg::PWR_SAMPLE;
      monitor_only      <= 1'b0;
      defaults_restored <= 1'b0;
      link_ready        <= 1'b0;
    end else begin
      state             <= next_state;
      monitor_only      <= next_monitor_only;
      defaults_restored <= next_defaults_restored;
      link_ready        <= next_link_ready;
    end
  end

  // Restore runs for exactly one cycle while the sequencer sits in its restore state.
  // The link stays closed through that cycle, so no write can race the wipe
  // and be lost under the factory values
  assign restore = (state == pid_regs_pkg::PWR_RESTORE); // R7

  // ----------------------------------------------------------------
  // Index decode
  // ----------------------------------------------------------------
  // Indices outside both loop ranges belong to other register groups
  assign rel1 = reg_index - pid_regs_pkg::LOOP1_BASE;
  assign rel2 = reg_index - pid_regs_pkg::LOOP2_BASE;
  assign hit1 = (reg_index >= pid_regs_pkg::LOOP1_BASE) && (rel1 < pid_regs_pkg::LOOP_SPAN);
  assign hit2 = (reg_index >= pid_regs_pkg::LOOP2_BASE) && (rel2 < pid_regs_pkg::LOOP_SPAN);

  // Writes are dropped until the sequencer runs and always on the monitoring variant
  assign bank_wr1 = reg_wr_en && hit1 && link_ready && !monitor_only; // R6
  assign bank_wr2 = reg_wr_en && hit2 && link_ready && !monitor_only; // R6

  // ----------------------------------------------------------------
  // Parameter banks, one per loop
  // ----------------------------------------------------------------
  pid_loop_bank loop1_bank (
    .clock   (clock),
    .arst_n  (arst_n),
    .wr_en   (bank_wr1),
    .restore (restore),
    .mirror  (!gain_sched_loop1), // R4
    .offset  (rel1[4:0]),
    .wr_data (reg_wr_data),
    .rd_data (bank_rd1)
  );

  pid_loop_bank loop2_bank (
    .clock   (clock),
    .arst_n  (arst_n),
    .wr_en   (bank_wr2),
    .restore (restore),
    .mirror  (!gain_sched_loop2), // R4
    .offset  (rel2[4:0]),
    .wr_data (reg_wr_data),
    .rd_data (bank_rd2)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Answer is registered one cycle after the request; costs a cycle of
  // latency but keeps every output straight from a flip-flop
  always_comb begin
    next_rd_valid = reg_rd_en && link_ready;
    next_rd_hit   = reg_rd_en && link_ready && (hit1 || hit2);
    next_rd_data  = rd_data;
    if (reg_rd_en && link_ready) begin
      if (monitor_only) next_rd_data = pid_regs_pkg::READ_NONSENSE; // R6
      else if (hit1) next_rd_data = bank_rd1; // R8
      else if (hit2) next_rd_data = bank_rd2; // R8
      else next_rd_data = pid_regs_pkg::WORD_DEFAULT;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_data  <= pid_regs_pkg::WORD_DEFAULT;
      rd_valid <= 1'b0;
      rd_hit   <= 1'b0;
    end else begin
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
      rd_hit   <= next_rd_hit;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_monitor_reads: assert property (@(posedge clock) disable iff (!arst_n) // R6
    (reg_rd_en && link_ready && monitor_only && hit1)
    |=> rd_valid && rd_hit && rd_data == pid_regs_pkg::READ_NONSENSE)
    else $error("Monitoring variant returned PID data");
  chk_monitor_writes: assert property (@(posedge clock) disable iff (!arst_n) // R6
    monitor_only |-> !bank_wr1 && !bank_wr2)
    else $error("Monitoring variant let a PID write through");
  chk_restore_keys: assert property (@(posedge clock) disable iff (!arst_n) // R7
    (state == pid_regs_pkg::PWR_SAMPLE && cancel_key && down_key)
    |=> restore ##1 (!restore && defaults_restored && link_ready))
    else $error("Key combination at power-up did not restore defaults");
  chk_no_restore: assert property (@(posedge clock) disable iff (!arst_n) // R7
    (state == pid_regs_pkg::PWR_SAMPLE && !(cancel_key && down_key))
    |=> (!restore && !defaults_restored && link_ready) [*2])
    else $error("Defaults restored without the key combination");
  chk_read_loop2: assert property (@(posedge clock) disable iff (!arst_n) // R8
    (reg_rd_en && link_ready && !monitor_only && hit2 && !bank_wr2)
    |=> rd_valid && rd_hit && rd_data == $past(bank_rd2))
    else $error("Loop 2 read did not return bank word one cycle later");

  // Read answers stand for one cycle only; a stray second pulse would
  // make the master count one read twice
  chk_valid_pulse: assert property (@(posedge clock) disable iff (!arst_n) // R8
    !(reg_rd_en && link_ready) |=> !rd_valid && !rd_hit)
    else $error("Read answer without an accepted read");
  chk_read_answer: assert property (@(posedge clock) disable iff (!arst_n) // R8
    (reg_rd_en && link_ready) |=> rd_valid)
    else $error("Accepted read got no answer");
  chk_data_holds: assert property (@(posedge clock) disable iff (!arst_n) // R8
    !(reg_rd_en && link_ready) |=> $stable(rd_data))
    else $error("Read word changed without a read");

  // Indices of other register groups answer with a plain zero word
  chk_hit_range: assert property (@(posedge clock) disable iff (!arst_n) // R6
    (reg_rd_en && link_ready && !hit1 && !hit2)
    |=> !rd_hit && rd_data == pid_regs_pkg::WORD_DEFAULT)
    else $error("Read outside the PID ranges reported a hit");

  // Power-up outcome is sticky until the next reset
  chk_ready_stays: assert property (@(posedge clock) disable iff (!arst_n) // R7
    link_ready |=> link_ready && $stable(monitor_only))
    else $error("Link closed or variant changed after power-up");
  chk_restore_sticky: assert property (@(posedge clock) disable iff (!arst_n) // R7
    defaults_restored |=> defaults_restored && !restore)
    else $error("Restore flag dropped or restore repeated");
  chk_sample_once: assert property (@(posedge clock) disable iff (!arst_n) // R7
    state != pid_regs_pkg::PWR_SAMPLE |=> state != pid_regs_pkg::PWR_SAMPLE)
    else $error("Keys sampled again after power-up");
  chk_wr_closed: assert property (@(posedge clock) disable iff (!arst_n) // R7
    !link_ready |-> !bank_wr1 && !bank_wr2)
    else $error("Write reached a bank before power-up finished");

endmodule // pid_parameter_register_access

`default_nettype wire

// [verification/pid_master_model.sv]
// Model of the supervisory master that reads and writes the PID registers
`timescale 1ns/1ps
`default_nettype none

module pid_master_model (
  input  wire logic        clock,
  output logic             reg_wr_en,
  output logic             reg_rd_en,
  output logic      [7:0]  reg_index,
  output logic      [15:0] reg_wr_data,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  input  wire logic        rd_hit
);
  // ----------------------------------------
  // Bus quiet at time zero
  // ----------------------------------------
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_index = 8'h00;
    reg_wr_data = 16'h0000;
  end

  // One word; strobe stays up so writes may follow back to back
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    @(negedge clock);
    reg_rd_en = 1'b0;
    reg_wr_en = 1'b1;
    reg_index = idx;
    reg_wr_data = d;
  endtask

  // Time in ms: high word to the first register, low word last
  task automatic wr_time(input logic [7:0] idx, input logic [31:0] ms);
    wr(idx, ms[31:16]);
    wr(idx + 8'h01, ms[15:0]);
  endtask

  // Release: lines flip so a stale value is never read as a request
  task automatic idle();
    @(negedge clock);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_index = ~reg_index;
    reg_wr_data = ~reg_wr_data;
  endtask

  // One read; answer taken half a cycle after the accepting edge
  task automatic rd(input logic [7:0] idx, output logic [15:0] d,
                    output logic v, output logic h);
    @(negedge clock);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b1;
    reg_index = idx;
    @(negedge clock);
    reg_rd_en = 1'b0;
    d = rd_data;
    v = rd_valid;
    h = rd_hit;
  endtask
endmodule // pid_master_model

`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the PID parameter register bank
`timescale 1ns/1ps
`default_nettype none

`define CHECK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("Error %s: expected %h, seen %h", what, exp, got); \
    end \
  end

module testbench;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        reg_wr_en, reg_rd_en, rd_valid, rd_hit;
  logic [7:0]  reg_index;
  logic [15:0] reg_wr_data, rd_data;
  logic        gain_sched_loop1 = 1'b0;
  logic        gain_sched_loop2 = 1'b0;
  logic        monitor_only_strap = 1'b0;
  logic        cancel_key = 1'b0;
  logic        down_key = 1'b0;
  logic        link_ready, monitor_only, defaults_restored;
  logic [15:0] shadow [0:1][0:17];
  logic        mon = 1'b0;
  int          errors = 0;
  int          tests_run = 0;
  integer      seed = 32'h5cf4_9b6a;
  logic [15:0] gain_corner [5] = '{16'h0000, 16'h2711, 16'hffff, 16'h0001, 16'h2710};

  // ----------------------------------------
  // Clock and instances
  // ----------------------------------------
  always #10 clock = ~clock;

  pid_parameter_register_access u_pid_parameter_register_access (
    .clock(clock), .arst_n(arst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_index(reg_index), .reg_wr_data(reg_wr_data),
    .gain_sched_loop1(gain_sched_loop1), .gain_sched_loop2(gain_sched_loop2),
    .monitor_only_strap(monitor_only_strap), .cancel_key(cancel_key),
    .down_key(down_key), .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit),
    .link_ready(link_ready), .monitor_only(monitor_only),
    .defaults_restored(defaults_restored));

  pid_master_model u_pid_master_model (
    .clock(clock), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_index(reg_index), .reg_wr_data(reg_wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_hit(rd_hit));

  // ----------------------------------------
  // Expectation helpers
  // ----------------------------------------
  function automatic logic hitf(logic [7:0] i);
    return (i >= 8'd96 && i <= 8'd113) || (i >= 8'd128 && i <= 8'd145);
  endfunction

  // Unscheduled loops read every set from the first one
  function automatic logic [15:0] exp_rd(logic [7:0] i);
    int l;
    int o;
    l = i[7];
    o = i - (i[7] ? 128 : 96);
    if (!hitf(i) || mon) return 16'h0000;
    if (o < 15 && !(l ? gain_sched_loop2 : gain_sched_loop1)) return shadow[l][o % 5];
    return shadow[l][o];
  endfunction

  // Write through the master and track it; gains clamp, unscheduled sets copy
  task automatic mwrite(logic [7:0] i, logic [15:0] x);
    int l;
    int o;
    l = i[7];
    o = i - (i[7] ? 128 : 96);
    u_pid_master_model.wr(i, x);
    if (!hitf(i) || mon) return;
    if (o < 15 && o % 5 == 0) x = (x < 16'd1) ? 16'd1 : (x > 16'd10000) ? 16'd10000 : x;
    if (o < 15 && !(l ? gain_sched_loop2 : gain_sched_loop1)) begin
      for (int s = 0; s < 3; s++) shadow[l][s * 5 + o % 5] = x;
    end else begin
      shadow[l][o] = x;
    end
  endtask

  task automatic check_rd(logic [7:0] i);
    logic [15:0] d;
    logic        v;
    logic        h;
    u_pid_master_model.rd(i, d, v, h);
    `CHECK("rd_valid", 1'b1, v)
    `CHECK("rd_hit", hitf(i), h)
    `CHECK("rd_data", exp_rd(i), d)
  endtask

  // Power-up with strap and keys; shadow returns to factory values
  task automatic do_reset(logic strap, logic c, logic d);
    int k;
    u_pid_master_model.idle();
    arst_n = 1'b0;
    monitor_only_strap = strap;
    cancel_key = c;
    down_key = d;
    mon = strap;
    for (int l = 0; l < 2; l++)
      for (int o = 0; o < 18; o++)
        shadow[l][o] = (o < 15 && o % 5 == 0) ? pid_regs_pkg::GAIN_DEFAULT : 16'h0000;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    @(negedge clock);
    `CHECK("link_ready early", !(c && d), link_ready)
    for (k = 0; k < 8 && link_ready !== 1'b1; k++) @(negedge clock);
    if (link_ready !== 1'b1) begin
      errors++;
      finish_test();
    end
    `CHECK("defaults_restored", c && d, defaults_restored)
    `CHECK("monitor_only", strap, monitor_only)
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic [7:0]  i;
    do_reset(1'b0, 1'b0, 1'b0);
    // Defaults, plus unmapped places on both sides of each range
    for (int n = 90; n < 151; n++) check_rd(n[7:0]);
    // Worked pairs back to back; a lone high must not move the low half
    gain_sched_loop2 = 1'b1;
    mwrite(8'd97, 16'h0001);
    mwrite(8'd98, 16'heb04);
    mwrite(8'd136, 16'h0000);
    mwrite(8'd137, 16'h0a28);
    mwrite(8'd99, 16'h00ff);
    mwrite(8'd98, 16'h1234);
    mwrite(8'd114, 16'hbeef);
    for (int n = 96; n < 146; n++) check_rd(n[7:0]);
    // Gain limits, read back through a mirrored set
    foreach (gain_corner[n]) begin
      mwrite(8'd101, gain_corner[n]);
      check_rd(8'd96);
      check_rd(8'd106);
    end
    // Random traffic with scheduling toggles
    repeat (400) begin
      r = $random(seed);
      i = (r[8] ? 8'd128 : 8'd96) + r[7:0] % 8'd18;
      if (r[15:12] == 4'h0) i = r[23:16];
      if (r[11:10] == 2'b00) begin
        u_pid_master_model.idle(); // Pending write lands under the old mode
        gain_sched_loop1 = r[12];
        gain_sched_loop2 = r[13];
      end
      if (r[9])
        check_rd(i);
      else if ((i - (i[7] ? 8'd128 : 8'd96)) % 8'd5 == 8'd0)
        mwrite(i, 16'd1 + 16'(r[31:16] % 10000));
      else
        mwrite(i, 16'($random(seed)));
    end
    // One key alone does nothing; both keys restore
    do_reset(1'b0, 1'b1, 1'b0);
    do_reset(1'b0, 1'b0, 1'b1);
    mwrite(8'd128, 16'h0200);
    do_reset(1'b0, 1'b1, 1'b1);
    check_rd(8'd128);
    // Monitoring variant ignores writes and reads back meaningless data
    do_reset(1'b1, 1'b0, 1'b0);
    mwrite(8'd96, 16'h0200);
    mwrite(8'd130, 16'h0005);
    check_rd(8'd96);
    check_rd(8'd130);
    check_rd(8'd50);
    finish_test();
  end

  // Guard against a hang anywhere above
  initial begin
    #1_000_000;
    errors++;
    finish_test();
  end
endmodule // testbench

`default_nettype wire
